/* hdl/sim_irq_map_low.sv */
// low interrupt source map: drives inputs 0..24 of the processor's
// interrupt controller and keeps the firmware interprocessor lines.
// assumes all sources and the APB master run on clock.
//
// Behaviour
// - controller has 64 inputs, we drive 0..24
// - inputs 0..3 are firmware-only level lines
// - write 0x9C sets, 0x98 clears lines
// - inputs 4..6 packet engine level requests
// - input 8 level-1 parity fail, level
// - inputs 9,10 core perfmon requests, level
// - inputs 12,13 cipher and accelerator, level
// - input 15 decompressor pulse, 14 level
// - input 16 storage, 23 storage message
// - inputs 17..20 from gp field 15:12
// - input 21 usb hs level, 22 either
// - input 24 subsystem summary, level
// - sense type per input reported outward
`default_nettype none

module sim_irq_map_low
  import sim_pkg::*;
(
  input  wire logic              clock,              // system clock, 200 MHz
  input  wire logic              srst,               // synchronous reset, active high
  input  wire logic              psel,               // apb select
  input  wire logic              penable,            // apb access phase
  input  wire logic              pwrite,             // apb direction
  input  wire logic [ADDR_W-1:0] paddr,              // apb byte address
  input  wire logic [DATA_W-1:0] pwdata,             // apb write data
  output logic      [DATA_W-1:0] prdata,             // apb read data
  output logic                   pready,             // apb ready
  output logic                   pslverr,            // apb error, unmapped
  input  wire logic              pktHostIfIrq,       // packet engine host interface
  input  wire logic              pktHostNocopyIrq,   // packet engine no-copy path
  input  wire logic              pktTimerIrq,        // packet engine timer
  input  wire logic              fabricIrq,          // fabric request
  input  wire logic              l1ParityFailIrq,    // level-1 parity fail
  input  wire logic              perfmonCore0Irq,    // core 0 perfmon
  input  wire logic              perfmonCore1Irq,    // core 1 perfmon
  input  wire logic              level2CacheIrq,     // level-2 cache
  input  wire logic              packetCipherIrq,    // packet cipher unit
  input  wire logic              securityAccelIrq,   // security accelerator
  input  wire logic              contentInspectIrq,  // content inspection
  input  wire logic              decompressIrq,      // decompressor, pulse
  input  wire logic              storageCtrlIrq,     // storage controller
  input  wire logic              usbHsCtrlIrq,       // usb high-speed ctrl
  input  wire logic              usbSsCtrlIrq,       // usb super-speed ctrl
  input  wire logic              storageMsgIrq,      // storage message request
  input  wire logic              subsysIrq,          // subsystem summary
  output logic      [NUM_IN-1:0] gicIrq,             // requests to controller 0..24
  output logic      [NUM_IN-1:0] gicEdge,            // 1: input is edge sensed
  output logic                   irqOut              // block interrupt, level
);

  // ==========================================================================
  // decode
  function automatic logic addrHit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] off);
    addrHit = (addr == off);
  endfunction

  logic                 setupPhase;
  logic                 accessPhase;
  logic                 wrAccess;
  logic                 mapped;

  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign wrAccess    = accessPhase & pwrite;
  // zero wait states: every access completes in its first access cycle
  assign pready      = 1'b1;

  always_comb begin
    mapped = addrHit(paddr, CFG_OUT_OFF)  | addrHit(paddr, IRQ_STAT_OFF) |
             addrHit(paddr, IRQ_MASK_OFF) | addrHit(paddr, RAW_OFF)      |
             addrHit(paddr, CTRL_OFF)     | addrHit(paddr, SENSE_OFF)    |
             addrHit(paddr, IPI_CLR_OFF)  | addrHit(paddr, IPI_SET_OFF);
  end

  assign pslverr = accessPhase & ~mapped;

  // ==========================================================================
  // registers
  logic [IPI_LINES-1:0] ipiLine;
  logic [DATA_W-1:0]    cfgOut;
  logic                 usbSsPulse;
  logic [EV_W-1:0]      irqStat;
  logic [EV_W-1:0]      irqMask;
  logic [NUM_IN-1:0]    pulseSel;

  logic [IPI_LINES-1:0] next_ipiLine;
  logic [DATA_W-1:0]    next_cfgOut;
  logic                 next_usbSsPulse;
  logic [EV_W-1:0]      next_irqStat;
  logic [EV_W-1:0]      next_irqMask;
  logic [DATA_W-1:0]    next_prdata;
  logic [NUM_IN-1:0]    next_gicEdge;
  logic [EV_W-1:0]      events;
  logic                 setWrite;
  logic                 clrWrite;

  assign setWrite = wrAccess & addrHit(paddr, IPI_SET_OFF);
  assign clrWrite = wrAccess & addrHit(paddr, IPI_CLR_OFF);

  always_comb begin
    next_ipiLine    = ipiLine;
    next_cfgOut     = cfgOut;
    next_usbSsPulse = usbSsPulse;
    next_irqMask    = irqMask;
    next_prdata     = prdata;

    // firmware set and clear
    // only firmware moves these lines; no hardware source reaches them
    if (clrWrite) begin
      next_ipiLine = ipiLine & ~pwdata[IPI_LINES-1:0];
    end
    if (setWrite) begin
      next_ipiLine = ipiLine | pwdata[IPI_LINES-1:0];
    end

    if (wrAccess && addrHit(paddr, CFG_OUT_OFF)) begin
      next_cfgOut = pwdata;
    end
    if (wrAccess && addrHit(paddr, CTRL_OFF)) begin
      next_usbSsPulse = pwdata[CTRL_USB_PULSE];
    end
    if (wrAccess && addrHit(paddr, IRQ_MASK_OFF)) begin
      next_irqMask = pwdata[EV_W-1:0];
    end

    // read data captured in the setup cycle so it is a flop at the access
    if (setupPhase) begin
      next_prdata = '0;
      case (1'b1)
        addrHit(paddr, CFG_OUT_OFF):  next_prdata = cfgOut;
        addrHit(paddr, IRQ_STAT_OFF): next_prdata[EV_W-1:0] = irqStat;
        addrHit(paddr, IRQ_MASK_OFF): next_prdata[EV_W-1:0] = irqMask;
        addrHit(paddr, RAW_OFF):      next_prdata[NUM_IN-1:0] = gicIrq;
        addrHit(paddr, CTRL_OFF):     next_prdata[CTRL_USB_PULSE] = usbSsPulse;
        addrHit(paddr, SENSE_OFF):    next_prdata[NUM_IN-1:0] = gicEdge;
        addrHit(paddr, IPI_CLR_OFF):  next_prdata[IPI_LINES-1:0] = ipiLine;
        addrHit(paddr, IPI_SET_OFF):  next_prdata[IPI_LINES-1:0] = ipiLine;
        default:                      next_prdata = '0;
      endcase
    end
  end

  // ==========================================================================
  // sticky status
  always_comb begin
    events                = '0;
    events[EV_IPI_SET]    = setWrite & (|pwdata[IPI_LINES-1:0]);
    events[EV_IPI_CLR]    = clrWrite & (|pwdata[IPI_LINES-1:0]);
    events[EV_DECOMP]     = gicIrq[IN_DECOMP];
    events[EV_BUS_ERR]    = pslverr;
    next_irqStat          = irqStat;
    if (wrAccess && addrHit(paddr, IRQ_STAT_OFF)) begin
      next_irqStat = irqStat & ~pwdata[EV_W-1:0];
    end
    // an event in the clearing cycle survives the clear
    next_irqStat = next_irqStat | events;
  end

  assign irqOut = |(irqStat & irqMask);

  // sense type map
  // either-type input follows the firmware mode so the controller can match
  always_comb begin
    next_gicEdge = PULSE_MAP | (EITHER_MAP & {NUM_IN{usbSsPulse}});
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ipiLine    <= IPI_RST;
      cfgOut     <= CFG_OUT_RST;
      usbSsPulse <= CTRL_RST;
      irqStat    <= '0;
      irqMask    <= MASK_RST;
      prdata     <= '0;
      gicEdge    <= PULSE_MAP;
    end else begin
      ipiLine    <= next_ipiLine;
      cfgOut     <= next_cfgOut;
      usbSsPulse <= next_usbSsPulse;
      irqStat    <= next_irqStat;
      irqMask    <= next_irqMask;
      prdata     <= next_prdata;
      gicEdge    <= next_gicEdge;
    end
  end

  assign pulseSel = next_gicEdge;

  // ==========================================================================
  // source map
  logic [NUM_IN-1:0] srcVec;

  always_comb begin
    srcVec = '0;
    srcVec[IN_IPI_BASE +: IPI_LINES] = ipiLine;
    srcVec[IN_PKT_HOST]   = pktHostIfIrq;
    srcVec[IN_PKT_NOCOPY] = pktHostNocopyIrq;
    srcVec[IN_PKT_TIMER]  = pktTimerIrq;
    srcVec[IN_FABRIC]     = fabricIrq;
    srcVec[IN_L1_PARITY]  = l1ParityFailIrq;
    srcVec[IN_PERF_CORE0] = perfmonCore0Irq;
    srcVec[IN_PERF_CORE1] = perfmonCore1Irq;
    srcVec[IN_L2_CACHE]   = level2CacheIrq;
    srcVec[IN_CIPHER]     = packetCipherIrq;
    srcVec[IN_SEC_ACCEL]  = securityAccelIrq;
    srcVec[IN_CONTENT]    = contentInspectIrq;
    srcVec[IN_DECOMP]     = decompressIrq;
    srcVec[IN_STORAGE]    = storageCtrlIrq;
    srcVec[IN_STOR_MSG]   = storageMsgIrq;
    srcVec[IN_GP_BASE +: GP_FIELD_W] = cfgOut[GP_FIELD_LSB +: GP_FIELD_W];
    srcVec[IN_USB_HS]     = usbHsCtrlIrq;
    srcVec[IN_USB_SS]     = usbSsCtrlIrq;
    srcVec[IN_SUBSYS]     = subsysIrq;
  end

  // per-input conditioning
  // every input takes one register stage so all share the same latency
  for (genvar i = 0; i < NUM_IN; i++) begin : g_src
    sim_src_if srcPort ();
    assign srcPort.srcLevel  = srcVec[i];
    assign srcPort.pulseMode = pulseSel[i];
    sim_src_cond u_cond (
      .clock (clock),
      .srst  (srst),
      .port  (srcPort.cond)
    );
    assign gicIrq[i] = srcPort.irqOut;
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  logic pastRst;
  always_ff @(posedge clock) begin
    pastRst <= srst;
  end

  ipi_set_a: assert property (setWrite && pwdata[0] |=> ipiLine[0])
    else $error("set write did not raise line 0");

  ipi_clear_a: assert property (clrWrite && pwdata[1] && !setWrite |=> !ipiLine[1])
    else $error("clear write did not drop line 1");

  ipi_hold_a: assert property (!setWrite && !clrWrite |=> ipiLine == $past(ipiLine))
    else $error("firmware line moved without a write");

  ipi_out_a: assert property (!pastRst |-> gicIrq[3:0] == $past(ipiLine))
    else $error("firmware lines not on inputs 0..3");

  pkt_map_a: assert property (!pastRst |->
      gicIrq[6:4] == $past({pktTimerIrq, pktHostNocopyIrq, pktHostIfIrq}))
    else $error("packet engine map wrong");

  parity_map_a: assert property (l1ParityFailIrq ##1 l1ParityFailIrq
      |-> gicIrq[IN_L1_PARITY])
    else $error("parity request not passed");

  perf_map_a: assert property (!pastRst |->
      gicIrq[10:9] == $past({perfmonCore1Irq, perfmonCore0Irq}))
    else $error("perfmon map wrong");

  crypto_map_a: assert property (!pastRst |->
      gicIrq[13:12] == $past({securityAccelIrq, packetCipherIrq}))
    else $error("crypto map wrong");

  decomp_pulse_a: assert property (gicIrq[IN_DECOMP] |=> !gicIrq[IN_DECOMP])
    else $error("decompressor request wider than one cycle");

  storage_map_a: assert property (!pastRst |->
      {gicIrq[IN_STOR_MSG], gicIrq[IN_STORAGE]} ==
      $past({storageMsgIrq, storageCtrlIrq}))
    else $error("storage map wrong");

  gp_map_a: assert property (!pastRst |->
      gicIrq[20:17] == $past(cfgOut[15:12]))
    else $error("gp field not on inputs 17..20");

  usb_level_a: assert property (!usbSsPulse && usbSsCtrlIrq ##1 !usbSsPulse
      |-> gicIrq[IN_USB_SS] && gicEdge[IN_USB_SS] == 1'b0)
    else $error("usb super-speed level mode wrong");

  summary_map_a: assert property (subsysIrq |=> gicIrq[IN_SUBSYS])
    else $error("subsystem summary not passed");

  sense_map_a: assert property (!pastRst |->
      gicEdge[15] && !gicEdge[14] && gicEdge[22] == $past(usbSsPulse))
    else $error("sense map wrong");

  level_hold_a: assert property (contentInspectIrq [*3]
      |-> gicIrq[IN_CONTENT] && $past(gicIrq[IN_CONTENT]))
    else $error("level request dropped while source high");

  irq_raise_a: assert property (pslverr && irqMask[EV_BUS_ERR] |=> irqOut)
    else $error("masked-in bus error did not raise interrupt");

  ipi_set_c:    cover property (setWrite ##1 gicIrq[0] ##[1:20] clrWrite);
  decomp_c:     cover property (decompressIrq ##2 irqStat[EV_DECOMP]);
  usb_pulse_c:  cover property (usbSsPulse && gicIrq[IN_USB_SS]);
  bus_error_c:  cover property (pslverr ##1 irqOut);

endmodule

`default_nettype wire

/* hdl/sim_src_cond.sv */
// per-input conditioner: registers a source and, in pulse mode, turns its
// rising edge into a single-cycle request.
// assumes the source is synchronous to clock.
`default_nettype none

module sim_src_cond
  import sim_pkg::*;
(
  input  wire logic clock,  // system clock
  input  wire logic srst,   // synchronous reset, active high
  sim_src_if.cond   port    // source in, request out
);

  logic prevLevel;
  logic irqReg;
  logic next_prevLevel;
  logic next_irqReg;

  // ==========================================================================
  // edge or level
  always_comb begin
    next_prevLevel = port.srcLevel;
    // in pulse mode a source held high for many cycles still yields one pulse only
    next_irqReg    = port.pulseMode ? (port.srcLevel & ~prevLevel) : port.srcLevel;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prevLevel <= 1'b0;
      irqReg    <= 1'b0;
    end else begin
      prevLevel <= next_prevLevel;
      irqReg    <= next_irqReg;
    end
  end

  assign port.irqOut = irqReg;

endmodule

`default_nettype wire

/* pkg/sim_pkg.sv */
// constants for the low interrupt source map: register offsets, field
// positions, input numbers and the pulse/level type map.
// assumes a single system clock and a 32-bit APB register port.
`default_nettype none

package sim_pkg;

  // ==========================================================================
  // sizes
  localparam int GIC_INPUTS  = 64;
  localparam int NUM_IN      = 25;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int IPI_LINES   = 4;
  localparam int EV_W        = 4;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] CFG_OUT_OFF  = 8'h00;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] RAW_OFF      = 8'h0c;
  localparam logic [ADDR_W-1:0] CTRL_OFF     = 8'h10;
  localparam logic [ADDR_W-1:0] SENSE_OFF    = 8'h14;
  localparam logic [ADDR_W-1:0] IPI_CLR_OFF  = 8'h98;
  localparam logic [ADDR_W-1:0] IPI_SET_OFF  = 8'h9c;

  // ==========================================================================
  // reset values
  localparam logic [DATA_W-1:0]    CFG_OUT_RST = 32'h0000_0000;
  localparam logic [EV_W-1:0]      MASK_RST    = 4'h0;
  localparam logic [IPI_LINES-1:0] IPI_RST     = 4'h0;
  localparam logic                 CTRL_RST    = 1'b0;

  // ==========================================================================
  // input numbers at the processor interrupt controller
  localparam int IN_IPI_BASE   = 0;
  localparam int IN_PKT_HOST   = 4;
  localparam int IN_PKT_NOCOPY = 5;
  localparam int IN_PKT_TIMER  = 6;
  localparam int IN_FABRIC     = 7;
  localparam int IN_L1_PARITY  = 8;
  localparam int IN_PERF_CORE0 = 9;
  localparam int IN_PERF_CORE1 = 10;
  localparam int IN_L2_CACHE   = 11;
  localparam int IN_CIPHER     = 12;
  localparam int IN_SEC_ACCEL  = 13;
  localparam int IN_CONTENT    = 14;
  localparam int IN_DECOMP     = 15;
  localparam int IN_STORAGE    = 16;
  localparam int IN_GP_BASE    = 17;
  localparam int IN_USB_HS     = 21;
  localparam int IN_USB_SS     = 22;
  localparam int IN_STOR_MSG   = 23;
  localparam int IN_SUBSYS     = 24;

  // general-purpose output field of the subsystem config register
  localparam int GP_FIELD_LSB  = 12;
  localparam int GP_FIELD_W    = 4;

  // type map: 1 = pulse (edge sensed), 0 = level; either-type inputs
  // follow the mode bit in the control register
  localparam logic [NUM_IN-1:0] PULSE_MAP  = 25'h000_8000;
  localparam logic [NUM_IN-1:0] EITHER_MAP = 25'h040_0000;
  localparam int CTRL_USB_PULSE = 0;

  // sticky event bits
  localparam int EV_IPI_SET = 0;
  localparam int EV_IPI_CLR = 1;
  localparam int EV_DECOMP  = 2;
  localparam int EV_BUS_ERR = 3;

endpackage

`default_nettype wire

/* pkg/sim_src_if.sv */
// one interrupt source between the map and its conditioner.
// assumes source and conditioner share the system clock.
`default_nettype none

interface sim_src_if;
  logic srcLevel;   // source request as presented by the map
  logic pulseMode;  // 1: emit a one-cycle pulse on a rising source
  logic irqOut;     // conditioned request toward the controller

  modport src  (output srcLevel, output pulseMode, input irqOut);
  modport cond (input srcLevel, input pulseMode, output irqOut);
endinterface

`default_nettype wire

/* tb/sim_src_model.sv */
// far-side model: peripheral sources feeding the map, plus the receiving
// controller's latch count for edge-sensed inputs.
// assumes srcReq is driven by the bench on the rising edge of clock.
`default_nettype none

module sim_src_model
  import sim_pkg::*;
(
  input  wire logic              clock,       // system clock
  input  wire logic              srst,        // synchronous reset, active high
  input  wire logic [NUM_IN-1:0] srcReq,      // bench request, bit n = input n
  input  wire logic [NUM_IN-1:0] gicIrq,      // requests seen by the controller
  input  wire logic [NUM_IN-1:0] gicEdge,     // sense type per input
  output logic      [NUM_IN-1:0] srcOut,      // source lines, bit n = input n
  output logic      [7:0]        pulseCount   // edge requests latched so far
);
  timeunit 1ns;
  timeprecision 1ps;

  logic reqPrev;
  logic decompPulse;

  // ==========================================================================
  // sources and receiver latch
  // decompressor one-clock pulse
  always_ff @(posedge clock) begin
    if (srst) begin
      reqPrev     <= 1'b0;
      decompPulse <= 1'b0;
      pulseCount  <= 8'h00;
    end else begin
      reqPrev     <= srcReq[IN_DECOMP];
      decompPulse <= srcReq[IN_DECOMP] & ~reqPrev;
      if ((gicIrq & gicEdge) != '0) begin
        pulseCount <= pulseCount + 8'h01;
      end
    end
  end

  always_comb begin
    srcOut            = srcReq;
    srcOut[IN_DECOMP] = decompPulse;
  end
endmodule

`default_nettype wire

/* tb/test_sim_irq_map_low.sv */
// self-checking bench for the low interrupt source map over APB.
// assumes sim_pkg, sim_src_if and the partner model are compiled first.
`default_nettype none

module test_sim_irq_map_low;
  timeunit 1ns;
  timeprecision 1ps;
  import sim_pkg::*;

  logic              clock = 1'b0;
  logic              srst  = 1'b1;
  logic              psel  = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [DATA_W-1:0] pwdata  = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [NUM_IN-1:0] src = '0;
  logic [NUM_IN-1:0] srcOut;
  logic [NUM_IN-1:0] gicIrq;
  logic [NUM_IN-1:0] gicEdge;
  logic              irqOut;
  logic [7:0]        pulseCount;
  int                bad_count = 0;
  int                n_checks  = 0;

  initial begin
    forever #2.5 clock = ~clock;
  end

  sim_irq_map_low sim_irq_map_low_inst (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pktHostIfIrq(srcOut[IN_PKT_HOST]), .pktHostNocopyIrq(srcOut[IN_PKT_NOCOPY]),
    .pktTimerIrq(srcOut[IN_PKT_TIMER]), .fabricIrq(srcOut[IN_FABRIC]),
    .l1ParityFailIrq(srcOut[IN_L1_PARITY]), .perfmonCore0Irq(srcOut[IN_PERF_CORE0]),
    .perfmonCore1Irq(srcOut[IN_PERF_CORE1]), .level2CacheIrq(srcOut[IN_L2_CACHE]),
    .packetCipherIrq(srcOut[IN_CIPHER]), .securityAccelIrq(srcOut[IN_SEC_ACCEL]),
    .contentInspectIrq(srcOut[IN_CONTENT]), .decompressIrq(srcOut[IN_DECOMP]),
    .storageCtrlIrq(srcOut[IN_STORAGE]), .usbHsCtrlIrq(srcOut[IN_USB_HS]),
    .usbSsCtrlIrq(srcOut[IN_USB_SS]), .storageMsgIrq(srcOut[IN_STOR_MSG]),
    .subsysIrq(srcOut[IN_SUBSYS]), .gicIrq(gicIrq), .gicEdge(gicEdge), .irqOut(irqOut)
  );

  sim_src_model sim_src_model_inst (
    .clock(clock), .srst(srst), .srcReq(src), .gicIrq(gicIrq), .gicEdge(gicEdge),
    .srcOut(srcOut), .pulseCount(pulseCount)
  );

  // ==========================================================================
  // tasks
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                     input string msg);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // setup, then access held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd,
                     output logic err);
    int waitCnt;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    waitCnt = 0;
    do begin
      @(posedge clock);
      waitCnt++;
    end while (pready !== 1'b1 && waitCnt < 50);
    if (waitCnt >= 50) begin
      bad_count++;
      $display("wrong value at %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] rd;
    logic              err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] rd;
    logic              err;
    apb(1'b0, a, '0, rd, err);
    chk(rd, exp, "register read");
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #100us;
    bad_count++;
    summarize();
  end

  // ==========================================================================
  // tests
  initial begin
    logic [NUM_IN-1:0] exp;
    logic [DATA_W-1:0] rd;
    logic              err;
    logic [7:0]        cnt;
    int                lvl[$];
    lvl = '{4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 16, 21, 22, 23, 24};
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    settle(1);
    chk(32'(gicIrq), 32'h0, "gic after reset");
    chk(32'(gicEdge), 32'h0000_8000, "sense after reset");
    chk(32'(irqOut), 32'h0, "irq after reset");
    rdchk(CFG_OUT_OFF, 32'h0);
    rdchk(IRQ_STAT_OFF, 32'h0);
    rdchk(IRQ_MASK_OFF, 32'h0);
    rdchk(CTRL_OFF, 32'h0);
    rdchk(SENSE_OFF, 32'h0000_8000);
    rdchk(IPI_SET_OFF, 32'h0);
    // unmapped access is refused and flagged
    apb(1'b0, 8'h40, '0, rd, err);
    chk(32'(err), 32'h1, "unmapped slverr");
    chk(rd, 32'h0, "unmapped data");
    rdchk(IRQ_STAT_OFF, 32'h8);
    wr(IRQ_MASK_OFF, 32'h8);
    settle(0);
    chk(32'(irqOut), 32'h1, "irq bus error");
    // a second refused access while unmasked keeps the interrupt up
    wr(8'h40, 32'h0);
    settle(0);
    chk(32'(irqOut), 32'h1, "irq second bus error");
    wr(IRQ_STAT_OFF, 32'h8);
    settle(0);
    chk(32'(irqOut), 32'h0, "irq cleared");
    wr(IRQ_MASK_OFF, 32'h0);
    // firmware lines set one by one, then cleared in pairs
    exp = '0;
    for (int i = 0; i < IPI_LINES; i++) begin
      wr(IPI_SET_OFF, 32'h1 << i);
      exp[i] = 1'b1;
      settle(1);
      chk(32'(gicIrq), 32'(exp), "ipi set");
    end
    rdchk(IPI_SET_OFF, 32'hf);
    rdchk(RAW_OFF, 32'hf);
    wr(IPI_CLR_OFF, 32'h5);
    settle(3);
    chk(32'(gicIrq), 32'ha, "ipi partial clear");
    wr(IPI_CLR_OFF, 32'ha);
    settle(1);
    chk(32'(gicIrq), 32'h0, "ipi clear");
    chk(32'(irqOut), 32'h0, "masked events");
    rdchk(IRQ_STAT_OFF, 32'h3);
    wr(IRQ_STAT_OFF, 32'h3);
    rdchk(IRQ_STAT_OFF, 32'h0);
    // level sources map to their own input and stand while held
    foreach (lvl[k]) begin
      exp = '0;
      exp[lvl[k]] = 1'b1;
      @(posedge clock);
      src <= exp;
      settle(1);
      chk(32'(gicIrq), 32'(exp), "level map");
      settle(2);
      chk(32'(gicIrq), 32'(exp), "level held");
      @(posedge clock);
      src <= '0;
      settle(1);
      chk(32'(gicIrq), 32'h0, "level removed");
    end
    // general-purpose field bits 15:12 drive inputs 17..20
    wr(CFG_OUT_OFF, 32'h0000_a000);
    settle(1);
    chk(32'(gicIrq), 32'h0014_0000, "gp field");
    rdchk(CFG_OUT_OFF, 32'h0000_a000);
    wr(CFG_OUT_OFF, 32'hffff_0fff);
    settle(1);
    chk(32'(gicIrq), 32'h0, "gp field clear");
    // decompressor pulse is latched once and raises its event
    wr(IRQ_MASK_OFF, 32'h4);
    cnt = pulseCount;
    @(posedge clock);
    src <= 25'h000_8000;
    settle(4);
    chk(32'(pulseCount), 32'(cnt + 8'h01), "decomp pulse count");
    chk(32'(gicIrq), 32'h0, "decomp pulse ended");
    chk(32'(irqOut), 32'h1, "decomp event irq");
    rdchk(IRQ_STAT_OFF, 32'h4);
    wr(IRQ_STAT_OFF, 32'h4);
    settle(0);
    chk(32'(irqOut), 32'h0, "decomp irq cleared");
    @(posedge clock);
    src <= '0;
    // super-speed usb in pulse mode: held source gives one pulse
    wr(CTRL_OFF, 32'h1);
    settle(1);
    chk(32'(gicEdge), 32'h0040_8000, "usb pulse sense");
    cnt = pulseCount;
    @(posedge clock);
    src <= 25'h040_0000;
    settle(6);
    chk(32'(pulseCount), 32'(cnt + 8'h01), "usb single pulse");
    chk(32'(gicIrq), 32'h0, "usb pulse ended");
    @(posedge clock);
    src <= '0;
    wr(CTRL_OFF, 32'h0);
    settle(1);
    chk(32'(gicEdge), 32'h0000_8000, "usb level sense");
    summarize();
  end
endmodule

`default_nettype wire
